// >>> shared/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_A     = 8'h05;
  localparam logic [7:0] IDX_PORT_E     = 8'h09;
  localparam logic [7:0] IDX_CORE_IRQ   = 8'h0b;
  localparam logic [7:0] IDX_IRQ_FLAGS  = 8'h0c;
  localparam logic [7:0] IDX_RESULT     = 8'h1e;
  localparam logic [7:0] IDX_CONTROL    = 8'h1f;
  localparam logic [7:0] IDX_DIR_A      = 8'h85;
  localparam logic [7:0] IDX_DIR_E      = 8'h89;
  localparam logic [7:0] IDX_IRQ_EN     = 8'h8c;
  localparam logic [7:0] IDX_PIN_CONFIG = 8'h9f;

  // reset values
  localparam logic [7:0] CORE_IRQ_RST   = 8'h00;
  localparam logic [7:0] IRQ_EN_RST     = 8'h00;
  localparam logic [5:0] DIR_A_RST      = 6'h3f;
  localparam logic [2:0] DIR_E_RST      = 3'h7;
  localparam logic [2:0] PIN_CONFIG_RST = 3'h0;
  localparam logic [1:0] CLOCK_SEL_RST  = 2'h0;
  localparam logic [2:0] CHANNEL_RST    = 3'h0;

  // adc_control field positions
  localparam int CTL_ON_BIT    = 0;
  localparam int CTL_GO_BIT    = 2;
  localparam int CTL_CHS_LSB   = 3;
  localparam int CTL_CS_LSB    = 6;
  // conv_done_flag / conv_done_irq_en position in flag and enable registers
  localparam int DONE_BIT      = 6;

  // conversion clock select codes
  localparam logic [1:0] CS_OSC2  = 2'h0;
  localparam logic [1:0] CS_OSC8  = 2'h1;
  localparam logic [1:0] CS_OSC32 = 2'h2;
  localparam logic [1:0] CS_RC    = 2'h3;
  // half bit periods in oscillator cycles for each divided source
  localparam logic [4:0] HALF_OSC2  = 5'h01;
  localparam logic [4:0] HALF_OSC8  = 5'h04;
  localparam logic [4:0] HALF_OSC32 = 5'h10;
  // 9.5 bit periods = 19 half periods; 2 bit periods = 4 half periods
  localparam logic [4:0] CONV_HALVES    = 5'h13;
  localparam logic [4:0] HOLDOFF_HALVES = 5'h04;

  // compare unit two mode that fires the converter
  localparam logic [3:0] TRIGGER_MODE = 4'hb;

  // timing: one oscillator period is one clock; one instruction is four
  localparam int CLOCK_NS     = 8;
  localparam int TOSC_NS      = 8;
  localparam int INSTR_NS     = 4 * TOSC_NS;
  localparam int INSTR_CYCLES = (INSTR_NS + CLOCK_NS - 1) / CLOCK_NS;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_RC_WAIT = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_HOLDOFF = 4'b1000
  } conv_state_t;
endpackage
`default_nettype wire

// >>> rtl/adc_conversion_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer #(
  parameter int INSTR_CYCLES = adc_seq_pkg::INSTR_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // system state
  input  wire logic        sleepMode,
  input  wire logic        rcTick,
  output logic             irq,
  output logic             wakeRequest,
  // compare unit two and timer
  input  wire logic [3:0]  compare2ModeField,
  input  wire logic        specialEventTrigger,
  output logic             timerClear,
  // converter core
  input  wire logic [7:0]  coreResult,
  output logic [2:0]       channelSelect,
  output logic             converterPowered,
  output logic             acquire,
  output logic             convRunning,
  output logic             bitStrobe,
  // port pins
  input  wire logic [5:0]  portAIn,
  output logic [5:0]       portAOut,
  output logic [5:0]       portAOe,
  input  wire logic [2:0]  portEIn,
  output logic [2:0]       portEOut,
  output logic [2:0]       portEOe
);

  // refuse a wait the 8-bit counter cannot hold
  if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255)
  begin : g_bad_instr
    $error("INSTR_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_CYCLES - 1);

  // map pin_config_field to an analog mask, bit n = input n analog
  function automatic logic [7:0] analogMask(input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    case (cfg)
      3'h0:    m = 8'hff;
      3'h1:    m = 8'hff;
      3'h2:    m = 8'h1f;
      3'h3:    m = 8'h1f;
      3'h4:    m = 8'h0b;
      3'h5:    m = 8'h03;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // half bit period length for the divided oscillator sources
  function automatic logic [4:0] halfLength(input logic [1:0] cs);
    logic [4:0] h;
    h = adc_seq_pkg::HALF_OSC2;
    case (cs)
      adc_seq_pkg::CS_OSC8:  h = adc_seq_pkg::HALF_OSC8;
      adc_seq_pkg::CS_OSC32: h = adc_seq_pkg::HALF_OSC32;
      default:               h = adc_seq_pkg::HALF_OSC2;
    endcase
    return h;
  endfunction

  // register state
  logic [1:0]  clockSelectReg;
  logic        goFlagReg;
  logic        converterOnReg;
  logic [7:0]  resultReg;
  logic        doneFlagReg;
  logic [7:0]  irqEnReg;
  logic [7:0]  coreIrqReg;
  logic [2:0]  pinConfigReg;
  logic [5:0]  dirAReg;
  logic [2:0]  dirEReg;

  // bus pipeline
  logic        wrPendReg;
  logic [7:0]  wrIdxReg;
  logic        accept;
  logic        mapped;
  logic [7:0]  readValue;
  logic [7:0]  wd;

  // sequencer
  adc_seq_pkg::conv_state_t stateReg;
  adc_seq_pkg::conv_state_t stateNext;
  logic [4:0]  prescaleReg;
  logic [4:0]  halfCntReg;
  logic [7:0]  waitCntReg;
  logic        halfTick;
  logic        isRc;
  logic        powerDown;
  logic        abortNow;
  logic        complete;
  logic        trigMatch;
  logic        trigGo;

  // analog masking of port reads
  logic [7:0]  anMask;
  logic [5:0]  portARead;
  logic [2:0]  portERead;

  assign anMask = analogMask(pinConfigReg);

  // analog-enabled pins read low; port a pin 4 is never analog
  for (genvar i = 0; i < 6; i++)
  begin : g_port_a
    localparam int AN = (i < 4) ? i : 4;
    if (i == 4)
    begin : g_digital
      assign portARead[i] = portAIn[i];
    end
    else
    begin : g_analog
      assign portARead[i] = portAIn[i] & ~anMask[AN];
    end
  end
  for (genvar j = 0; j < 3; j++)
  begin : g_port_e
    assign portERead[j] = portEIn[j] & ~anMask[5 + j];
  end

  // address phase decode; word transfers only, sizes are not checked
  assign accept = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign wd     = hwdata[7:0];

  // read mux from the address phase; unmapped addresses read zero
  always_comb
  begin
    readValue = 8'h00;
    if (mapped)
    begin
      case (haddr[9:2])
        adc_seq_pkg::IDX_PORT_A:     readValue = {2'h0, portARead};
        adc_seq_pkg::IDX_PORT_E:     readValue = {5'h00, portERead};
        adc_seq_pkg::IDX_CORE_IRQ:   readValue = coreIrqReg;
        adc_seq_pkg::IDX_IRQ_FLAGS:  readValue = 8'(doneFlagReg) << adc_seq_pkg::DONE_BIT;
        adc_seq_pkg::IDX_RESULT:     readValue = resultReg;
        adc_seq_pkg::IDX_CONTROL:    readValue = {clockSelectReg, channelSelect, goFlagReg, 1'b0,
                                                  converterOnReg};
        adc_seq_pkg::IDX_DIR_A:      readValue = {2'h0, dirAReg};
        adc_seq_pkg::IDX_DIR_E:      readValue = {5'h00, dirEReg};
        adc_seq_pkg::IDX_IRQ_EN:     readValue = irqEnReg;
        adc_seq_pkg::IDX_PIN_CONFIG: readValue = {5'h00, pinConfigReg};
        default:                     readValue = 8'h00;
      endcase
    end
  end

  // bus slave: zero wait states, read data registered at the address edge
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wrPendReg <= 1'b0;
      wrIdxReg  <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendReg <= accept && hwrite && mapped;
      if (accept)
      begin
        wrIdxReg <= haddr[9:2];
        if (!hwrite)
          hrdata <= {24'h0, readValue};
      end
    end
  end

  // write strobes in the data phase
  logic wrControl;
  logic wrResult;
  logic wrFlags;
  assign wrControl = wrPendReg && (wrIdxReg == adc_seq_pkg::IDX_CONTROL);
  assign wrResult  = wrPendReg && (wrIdxReg == adc_seq_pkg::IDX_RESULT);
  assign wrFlags   = wrPendReg && (wrIdxReg == adc_seq_pkg::IDX_IRQ_FLAGS);

  // configuration fields of adc_control
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      clockSelectReg <= adc_seq_pkg::CLOCK_SEL_RST;
      channelSelect  <= adc_seq_pkg::CHANNEL_RST;
      converterOnReg <= 1'b0;
    end
    else if (wrControl)
    begin
      clockSelectReg <= wd[adc_seq_pkg::CTL_CS_LSB +: 2];
      channelSelect  <= wd[adc_seq_pkg::CTL_CHS_LSB +: 3];
      converterOnReg <= wd[adc_seq_pkg::CTL_ON_BIT];
    end
  end

  // plain storage registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irqEnReg     <= adc_seq_pkg::IRQ_EN_RST;
      coreIrqReg   <= adc_seq_pkg::CORE_IRQ_RST;
      pinConfigReg <= adc_seq_pkg::PIN_CONFIG_RST;
    end
    else if (wrPendReg)
    begin
      case (wrIdxReg)
        adc_seq_pkg::IDX_IRQ_EN:     irqEnReg     <= wd;
        adc_seq_pkg::IDX_CORE_IRQ:   coreIrqReg   <= wd;
        adc_seq_pkg::IDX_PIN_CONFIG: pinConfigReg <= wd[2:0];
        default:                     ;
      endcase
    end
  end

  // port latches and directions; reset leaves every pin an input
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      dirAReg  <= adc_seq_pkg::DIR_A_RST;
      dirEReg  <= adc_seq_pkg::DIR_E_RST;
      portAOe  <= 6'h00;
      portEOe  <= 3'h0;
      portAOut <= 6'h00;
      portEOut <= 3'h0;
    end
    else if (wrPendReg)
    begin
      case (wrIdxReg)
        adc_seq_pkg::IDX_PORT_A: portAOut <= wd[5:0];
        adc_seq_pkg::IDX_PORT_E: portEOut <= wd[2:0];
        adc_seq_pkg::IDX_DIR_A:
        begin
          dirAReg <= wd[5:0];
          portAOe <= ~wd[5:0];
        end
        adc_seq_pkg::IDX_DIR_E:
        begin
          dirEReg <= wd[2:0];
          portEOe <= ~wd[2:0];
        end
        default: ;
      endcase
    end
  end

  // conversion clock: divided oscillator or ticks from the rc source
  assign isRc      = (clockSelectReg == adc_seq_pkg::CS_RC);
  assign halfTick  = isRc ? rcTick : (prescaleReg == halfLength(clockSelectReg) - 5'h01);
  assign powerDown = sleepMode && !isRc;
  assign trigMatch = specialEventTrigger && (compare2ModeField == adc_seq_pkg::TRIGGER_MODE);
  assign trigGo    = trigMatch && converterOnReg;

  // abort on go cleared, converter off, or sleep with a divided clock
  assign abortNow = ((stateReg == adc_seq_pkg::ST_CONVERT) || (stateReg == adc_seq_pkg::ST_RC_WAIT))
                    && (!goFlagReg || !converterOnReg || powerDown);
  assign complete = (stateReg == adc_seq_pkg::ST_CONVERT) && !abortNow && halfTick
                    && (halfCntReg == adc_seq_pkg::CONV_HALVES - 5'h01);

  // next state
  always_comb
  begin
    stateNext = stateReg;
    case (stateReg)
      adc_seq_pkg::ST_IDLE:
        if (goFlagReg && converterOnReg && !powerDown)
          stateNext = isRc ? adc_seq_pkg::ST_RC_WAIT : adc_seq_pkg::ST_CONVERT;
      adc_seq_pkg::ST_RC_WAIT:
        if (abortNow)
          stateNext = adc_seq_pkg::ST_HOLDOFF;
        else if (waitCntReg == INSTR_LAST)
          stateNext = adc_seq_pkg::ST_CONVERT;
      adc_seq_pkg::ST_CONVERT:
        if (abortNow || complete)
          stateNext = adc_seq_pkg::ST_HOLDOFF;
      adc_seq_pkg::ST_HOLDOFF:
        if (halfTick && halfCntReg == adc_seq_pkg::HOLDOFF_HALVES - 5'h01)
          stateNext = adc_seq_pkg::ST_IDLE;
      default:
        stateNext = adc_seq_pkg::ST_IDLE;
    endcase
  end

  // state and counters; counts restart on every state change
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      stateReg    <= adc_seq_pkg::ST_IDLE;
      prescaleReg <= 5'h00;
      halfCntReg  <= 5'h00;
      waitCntReg  <= 8'h00;
    end
    else
    begin
      stateReg <= stateNext;
      if (stateNext != stateReg)
      begin
        prescaleReg <= 5'h00;
        halfCntReg  <= 5'h00;
        waitCntReg  <= 8'h00;
      end
      else
      begin
        waitCntReg  <= waitCntReg + 8'h01;
        prescaleReg <= halfTick ? 5'h00 : prescaleReg + 5'h01;
        if (halfTick)
          halfCntReg <= halfCntReg + 5'h01;
      end
    end
  end

  // go flag: trigger set beats any clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (reset)
      goFlagReg <= 1'b0;
    else
    begin
      if (complete || powerDown)
        goFlagReg <= 1'b0;
      if (wrControl)
        goFlagReg <= wd[adc_seq_pkg::CTL_GO_BIT];
      if (trigGo)
        goFlagReg <= 1'b1;
    end
  end

  // result has no reset so it survives every reset but power-up
  always_ff @(posedge clock)
  begin
    if (complete)
      resultReg <= coreResult;
    else if (wrResult)
      resultReg <= wd;
  end

  // done flag: cleared by writing one, a new completion wins
  always_ff @(posedge clock)
  begin
    if (reset)
      doneFlagReg <= 1'b0;
    else if (complete)
      doneFlagReg <= 1'b1;
    else if (wrFlags && wd[adc_seq_pkg::DONE_BIT])
      doneFlagReg <= 1'b0;
  end

  // registered outputs toward the core, timer and cpu
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq              <= 1'b0;
      wakeRequest      <= 1'b0;
      timerClear       <= 1'b0;
      converterPowered <= 1'b0;
      acquire          <= 1'b0;
      convRunning      <= 1'b0;
      bitStrobe        <= 1'b0;
    end
    else
    begin
      irq              <= doneFlagReg && irqEnReg[adc_seq_pkg::DONE_BIT];
      wakeRequest      <= sleepMode && doneFlagReg && irqEnReg[adc_seq_pkg::DONE_BIT];
      timerClear       <= trigMatch;
      converterPowered <= converterOnReg && !powerDown;
      acquire          <= converterOnReg && !powerDown
                          && (stateNext == adc_seq_pkg::ST_IDLE
                              || stateNext == adc_seq_pkg::ST_RC_WAIT);
      convRunning      <= (stateNext == adc_seq_pkg::ST_CONVERT);
      bitStrobe        <= (stateReg == adc_seq_pkg::ST_CONVERT) && halfTick && !abortNow;
    end
  end

endmodule
`default_nettype wire

// >>> bench/adc_seq_props.sv
`timescale 1ns/1ns
`default_nettype none
module adc_seq_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // watched ports
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       irq,
  input wire logic [3:0] compare2ModeField,
  input wire logic       specialEventTrigger,
  input wire logic       timerClear,
  input wire logic       converterPowered,
  input wire logic       acquire,
  input wire logic       convRunning,
  input wire logic       bitStrobe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic [5:0] strobeCount;
  // half-period strobes in the current run; cleared between runs
  always_ff @(posedge clock)
  begin
    if (reset || !convRunning)
      strobeCount <= 6'h00;
    else if (bitStrobe)
      strobeCount <= strobeCount + 6'h01;
  end
  // zero wait states, always okay
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  a_trigger_clears: assert property (
    specialEventTrigger && compare2ModeField == adc_seq_pkg::TRIGGER_MODE |=> timerClear)
    else $error("trigger did not clear the timer");
  a_clear_cause: assert property (
    timerClear |-> $past(specialEventTrigger) && $past(compare2ModeField) == adc_seq_pkg::TRIGGER_MODE)
    else $error("timer cleared without a trigger");
  a_run_no_sample: assert property (convRunning |-> !acquire)
    else $error("sampling while converting");
  a_holdoff_gap: assert property ($fell(convRunning) |-> !acquire [*4])
    else $error("acquisition resumed too early");
  // the last of the 19 half periods lands after the run flag drops, so 18 are seen
  a_strobe_limit: assert property (strobeCount <= 6'h12)
    else $error("too many half periods in one run");
  a_sample_powered: assert property (acquire |-> converterPowered)
    else $error("sampling while powered down");
  a_reset_quiet: assert property (
    $fell(reset) |-> !convRunning && !converterPowered && !timerClear && !irq)
    else $error("outputs active after reset");
  // main scenarios reached
  c_conv_done: cover property ($fell(convRunning));
  c_trigger: cover property (timerClear);
  c_irq: cover property (irq);
endmodule
bind adc_conversion_sequencer adc_seq_props i_adc_seq_props (
  .clock(clock), .reset(reset), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .compare2ModeField(compare2ModeField), .specialEventTrigger(specialEventTrigger),
  .timerClear(timerClear), .converterPowered(converterPowered), .acquire(acquire),
  .convRunning(convRunning), .bitStrobe(bitStrobe));
`default_nettype wire

// >>> bench/adc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // control from the sequencer
  input  wire logic [2:0] channelSelect,
  input  wire logic       converterPowered,
  input  wire logic       convRunning,
  // answers
  output logic [7:0]      coreResult,
  output logic            rcTick
);
  logic [1:0] rcPhase;
  // rc source: one half bit period per three clocks, stopped while unpowered
  always_ff @(posedge clock)
  begin
    if (reset || !converterPowered)
      rcPhase <= 2'h0;
    else
      rcPhase <= (rcPhase == 2'h2) ? 2'h0 : rcPhase + 2'h1;
  end
  assign rcTick = (rcPhase == 2'h2);
  // value tracks the selected input; toggles outside a run so a stray sample shows
  always_ff @(posedge clock)
  begin
    if (reset)
      coreResult <= 8'h5a;
    else if (convRunning)
      coreResult <= {channelSelect, 5'h0a};
    else
      coreResult <= ~coreResult;
  end
endmodule
`default_nettype wire

// >>> bench/tb_adc_conversion_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_adc_conversion_sequencer;
  logic        clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, sleepMode = 1'b0;
  logic        specialEventTrigger = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  compare2ModeField = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [7:0]  coreResult, q, lastRes;
  logic [2:0]  channelSelect, portEOut, portEOe;
  logic [5:0]  portAOut, portAOe;
  logic        hreadyout, hresp, rcTick, irq, wakeRequest, timerClear;
  logic        converterPowered, acquire, convRunning, bitStrobe;
  int          miscompares = 0, n_checks = 0, runLen = 0, lastRunLen = 0, n;
  int          halves [3] = '{1, 4, 16};
  logic [7:0]  rstIdx [7] = '{8'h1f, 8'h0c, 8'h8c, 8'h85, 8'h89, 8'h9f, 8'h40};
  logic [7:0]  rstVal [7] = '{8'h00, 8'h00, 8'h00, 8'h3f, 8'h07, 8'h00, 8'h00};

  adc_conversion_sequencer i_adc_conversion_sequencer (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sleepMode(sleepMode), .rcTick(rcTick), .irq(irq), .wakeRequest(wakeRequest),
    .compare2ModeField(compare2ModeField), .specialEventTrigger(specialEventTrigger),
    .timerClear(timerClear), .coreResult(coreResult), .channelSelect(channelSelect),
    .converterPowered(converterPowered), .acquire(acquire), .convRunning(convRunning),
    .bitStrobe(bitStrobe), .portAIn(6'h3f), .portAOut(portAOut), .portAOe(portAOe),
    .portEIn(3'h7), .portEOut(portEOut), .portEOe(portEOe));
  adc_core_model i_adc_core_model (
    .clock(clock), .reset(reset), .channelSelect(channelSelect), .converterPowered(converterPowered),
    .convRunning(convRunning), .coreResult(coreResult), .rcTick(rcTick));

  // 125 MHz
  initial
  begin
    forever #4 clock = ~clock;
  end
  // length of the latest run, in clocks
  always @(posedge clock)
  begin
    if (convRunning === 1'b1)
      runLen <= runLen + 1;
    else if (runLen != 0)
    begin
      lastRunLen <= runLen;
      runLen <= 0;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single transfer; address phase then data phase, each held until hready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask
  task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00);
    check(what, q, exp);
    check("read upper", {15'h0, |hrdata[31:8]}, 16'h0);
  endtask
  function automatic logic [7:0] ctl(input logic [1:0] cs, input logic [2:0] ch, input logic go, input logic on);
    return {cs, ch, go, 1'b0, on};
  endfunction
  task automatic waitHold;
    while (convRunning === 1'b1) @(posedge clock);
    for (n = 0; n < 400 && acquire !== 1'b1; n++) @(posedge clock);
  endtask
  // turn on first, go in a later write
  task automatic convert(input logic [1:0] cs, input logic [2:0] ch);
    wr(adc_seq_pkg::IDX_CONTROL, ctl(cs, ch, 1'b0, 1'b1));
    wr(adc_seq_pkg::IDX_CONTROL, ctl(cs, ch, 1'b1, 1'b1));
    for (n = 0; n < 60 && convRunning !== 1'b1; n++) @(posedge clock);
    check("mux", channelSelect, ch);
  endtask
  task automatic done(input logic [1:0] cs, input logic [2:0] ch);
    rd("go", adc_seq_pkg::IDX_CONTROL, ctl(cs, ch, 1'b0, 1'b1));
    rd("result", adc_seq_pkg::IDX_RESULT, {ch, 5'h0a});
    rd("flag", adc_seq_pkg::IDX_IRQ_FLAGS, 8'h40);
    wr(adc_seq_pkg::IDX_IRQ_FLAGS, 8'h40);
    rd("flag clear", adc_seq_pkg::IDX_IRQ_FLAGS, 8'h00);
    lastRes = {ch, 5'h0a};
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a hang ends the run; normal run is far shorter
  initial
  begin
    repeat (60000) @(posedge clock);
    miscompares++;
    give_verdict;
  end

  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) rd("reset value", rstIdx[i], rstVal[i]);
    $display("test reset values done");
    // each divided clock, with timing of run and holdoff
    for (int i = 0; i < 3; i++)
    begin
      convert(2'(i), 3'(3 * i + 1));
      waitHold;
      check("run length", 16'(lastRunLen), 16'(19 * halves[i]));
      check("holdoff", n >= 4 * halves[i], 1'b1);
      done(2'(i), 3'(3 * i + 1));
    end
    $display("test conversions done");
    wr(adc_seq_pkg::IDX_IRQ_EN, 8'h40);
    convert(2'h0, 3'h2);
    waitHold;
    #1;
    check("irq", irq, 1'b1);
    wr(adc_seq_pkg::IDX_IRQ_EN, 8'h00);
    @(posedge clock);
    #1;
    check("irq masked", irq, 1'b0);
    wr(adc_seq_pkg::IDX_IRQ_EN, 8'h40);
    done(2'h0, 3'h2);
    @(posedge clock);
    #1;
    check("irq cleared", irq, 1'b0);
    $display("test interrupt done");
    // abort keeps a software-written result
    wr(adc_seq_pkg::IDX_RESULT, 8'ha5);
    convert(2'h2, 3'h2);
    repeat (20) @(posedge clock);
    wr(adc_seq_pkg::IDX_CONTROL, ctl(2'h2, 3'h2, 1'b0, 1'b1));
    waitHold;
    check("abort wait", n >= 64, 1'b1);
    check("resume", acquire, 1'b1);
    rd("abort result", adc_seq_pkg::IDX_RESULT, 8'ha5);
    rd("abort flag", adc_seq_pkg::IDX_IRQ_FLAGS, 8'h00);
    $display("test abort done");
    // rc source: delayed start, runs through sleep, wakes
    wr(adc_seq_pkg::IDX_CONTROL, ctl(2'h3, 3'h6, 1'b0, 1'b1));
    wr(adc_seq_pkg::IDX_CONTROL, ctl(2'h3, 3'h6, 1'b1, 1'b1));
    @(posedge clock);
    #1;
    check("rc delay", convRunning, 1'b0);
    @(posedge clock);
    sleepMode <= 1'b1;
    for (n = 0; n < 60 && convRunning !== 1'b1; n++) @(posedge clock);
    waitHold;
    #1;
    check("wake", wakeRequest, 1'b1);
    check("rc powered", converterPowered, 1'b1);
    @(posedge clock);
    sleepMode <= 1'b0;
    done(2'h3, 3'h6);
    $display("test rc sleep done");
    convert(2'h1, 3'h3);
    @(posedge clock);
    sleepMode <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("sleep power", converterPowered, 1'b0);
    check("sleep abort", convRunning, 1'b0);
    @(posedge clock);
    sleepMode <= 1'b0;
    rd("sleep control", adc_seq_pkg::IDX_CONTROL, ctl(2'h1, 3'h3, 1'b0, 1'b1));
    rd("sleep flag", adc_seq_pkg::IDX_IRQ_FLAGS, 8'h00);
    waitHold;
    $display("test sleep abort done");
    // trigger: mode 1011 on, mode 1011 off, other mode on
    for (int i = 0; i < 3; i++)
    begin
      wr(adc_seq_pkg::IDX_CONTROL, ctl(2'h0, 3'h1, 1'b0, i != 1));
      @(posedge clock);
      compare2ModeField <= (i == 2) ? 4'ha : 4'hb;
      specialEventTrigger <= 1'b1;
      @(posedge clock);
      specialEventTrigger <= 1'b0;
      #1;
      check("timer clear", timerClear, i != 2);
      @(posedge clock);
      #1;
      check("trigger start", convRunning, i == 0);
      if (i == 0)
      begin
        waitHold;
        done(2'h0, 3'h1);
      end
      rd("trigger go", adc_seq_pkg::IDX_CONTROL, ctl(2'h0, 3'h1, 1'b0, i != 1));
    end
    $display("test trigger done");
    for (int i = 0; i < 3; i++)
    begin
      wr(adc_seq_pkg::IDX_PIN_CONFIG, 8'(2 * i + (i > 0 ? 2 : 0)));
      rd("port a", adc_seq_pkg::IDX_PORT_A, i == 0 ? 8'h10 : (i == 1 ? 8'h34 : 8'h3f));
      rd("port e", adc_seq_pkg::IDX_PORT_E, i == 0 ? 8'h00 : 8'h07);
    end
    wr(adc_seq_pkg::IDX_PORT_A, 8'h15);
    wr(adc_seq_pkg::IDX_PORT_E, 8'h06);
    wr(adc_seq_pkg::IDX_DIR_E, 8'h02);
    wr(adc_seq_pkg::IDX_DIR_A, 8'h00);
    #1;
    check("port a drive", portAOe, 6'h3f);
    check("port a out", portAOut, 6'h15);
    check("port e out", portEOut, 3'h6);
    check("port e drive", portEOe, 3'h5);
    $display("test ports done");
    // reset in mid-run
    convert(2'h2, 3'h4);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("reset abort", convRunning, 1'b0);
    check("reset pins", portAOe, 6'h00);
    check("reset pins e", portEOe, 3'h0);
    check("reset latch", portAOut, 6'h00);
    rd("reset control", adc_seq_pkg::IDX_CONTROL, 8'h00);
    rd("reset result", adc_seq_pkg::IDX_RESULT, lastRes);
    rd("reset config", adc_seq_pkg::IDX_PIN_CONFIG, 8'h00);
    $display("test reset run done");
    give_verdict;
  end
endmodule
`default_nettype wire
